// File: logic/reset_cause_pkg.sv
package reset_cause_pkg;
  // Register address and data layout
  localparam logic [7:0] ADDR_RESET_CAUSE = 8'hEF;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned BIT_USB = 7;
  localparam int unsigned BIT_FLASH = 6;
  localparam int unsigned BIT_SOFT = 4;
  localparam int unsigned BIT_MCD = 2;
  localparam int unsigned BIT_POR = 1;
  localparam int unsigned BIT_PIN = 0;
  localparam logic [7:0] RESET_CAUSE_POR_VALUE = 8'h02;
  localparam logic [7:0] READ_ZERO = 8'h00;

  // Synchronised reset-source inputs, by index
  localparam int unsigned SRC_PIN = 0;
  localparam int unsigned SRC_SUPPLY_LOW = 1;
  localparam int unsigned SRC_MCD = 2;
  localparam int unsigned SRC_FLASH = 3;
  localparam int unsigned SRC_USB = 4;
  localparam int unsigned NUM_SRC = 5;

  // Timing
  localparam int unsigned CLK_PERIOD_NS = 25;
  localparam int unsigned RESET_HOLD_NS = 100;
  localparam int unsigned RESET_HOLD_CYC =
    (RESET_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned SYNC_STAGES = 2;

  typedef enum logic {
    ST_RUN,
    ST_HOLD
  } seq_state_e;
endpackage

// File: logic/source_sync_if.sv
`timescale 1ns/100ps
interface source_sync_if #(
  parameter int unsigned WIDTH = 5
);
  logic [WIDTH-1:0] raw;
  logic [WIDTH-1:0] synced;
  modport sync (input raw, output synced);
  modport user (output raw, input synced);
endinterface

// File: logic/source_sync.sv
`timescale 1ns/100ps
module source_sync #(
  parameter int unsigned WIDTH = 5
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Sources
  source_sync_if.sync src
);
  logic [WIDTH-1:0] meta_q, meta_d;
  logic [WIDTH-1:0] sync_q, sync_d;

  if (WIDTH < 1) begin : g_chk
    $error("source_sync: WIDTH must be at least 1");
  end

  always_comb begin
    meta_d = src.raw;
    sync_d = meta_q;
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign src.synced = sync_q;
endmodule

// File: logic/reset_cause_reg.sv
`timescale 1ns/100ps
module reset_cause_reg #(
  parameter int unsigned HOLD_CYC = reset_cause_pkg::RESET_HOLD_CYC
) (
  // Clock and power-on reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Special-function register port
  input wire logic [7:0] sfr_addr_i,
  input wire logic sfr_wr_i,
  input wire logic sfr_rd_i,
  input wire logic [7:0] sfr_wdata_i,
  output logic [7:0] sfr_rdata_o,
  // Reset sources from pins and monitors
  input wire logic pin_reset_i,
  input wire logic supply_low_i,
  input wire logic missing_clock_i,
  input wire logic flash_fault_i,
  input wire logic usb_reset_i,
  // Reset request and source enables
  output logic sys_reset_o,
  output logic usb_reset_en_o,
  output logic missing_clock_en_o,
  output logic supply_monitor_sel_o
);
  localparam int unsigned CNT_W = $clog2(HOLD_CYC + 1);

  if (HOLD_CYC < 1) begin : g_chk
    $error("reset_cause_reg: HOLD_CYC must be at least 1");
  end

  source_sync_if #(.WIDTH(reset_cause_pkg::NUM_SRC)) src_if ();

  // Raw source levels, one driver for the whole vector
  always_comb begin
    src_if.raw = '0;
    src_if.raw[reset_cause_pkg::SRC_PIN] = pin_reset_i;
    src_if.raw[reset_cause_pkg::SRC_SUPPLY_LOW] = supply_low_i;
    src_if.raw[reset_cause_pkg::SRC_MCD] = missing_clock_i;
    src_if.raw[reset_cause_pkg::SRC_FLASH] = flash_fault_i;
    src_if.raw[reset_cause_pkg::SRC_USB] = usb_reset_i;
  end

  source_sync #(
    .WIDTH(reset_cause_pkg::NUM_SRC)
  ) u_sync (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .src(src_if)
  );

  function automatic logic hit(input logic [7:0] addr);
    hit = (addr == reset_cause_pkg::ADDR_RESET_CAUSE);
  endfunction

  // Cause flags and source enables
  reset_cause_pkg::seq_state_e state_q, state_d;
  logic [CNT_W-1:0] cnt_q, cnt_d;
  logic usb_f_q, usb_f_d;
  logic flash_f_q, flash_f_d;
  logic soft_f_q, soft_f_d;
  logic mcd_f_q, mcd_f_d;
  logic por_f_q, por_f_d;
  logic pin_f_q, pin_f_d;
  logic usb_en_q, usb_en_d;
  logic mcd_en_q, mcd_en_d;
  logic vmon_q, vmon_d;
  logic sys_reset_q, sys_reset_d;
  logic [7:0] rdata_q, rdata_d;
  logic wr_hit, soft_req, trig;
  logic [reset_cause_pkg::NUM_SRC-1:0] s;

  always_comb begin
    s = src_if.synced;
    wr_hit = sfr_wr_i && hit(sfr_addr_i);
    soft_req = wr_hit && sfr_wdata_i[reset_cause_pkg::BIT_SOFT];
    state_d = state_q;
    cnt_d = cnt_q;
    usb_f_d = usb_f_q;
    flash_f_d = flash_f_q;
    soft_f_d = soft_f_q;
    mcd_f_d = mcd_f_q;
    por_f_d = por_f_q;
    pin_f_d = pin_f_q;
    usb_en_d = usb_en_q;
    mcd_en_d = mcd_en_q;
    vmon_d = vmon_q;
    sys_reset_d = sys_reset_q;
    trig = 1'b0;
    if (wr_hit) begin
      // Only enable bits take write data; cause flags stay latched
      usb_en_d = sfr_wdata_i[reset_cause_pkg::BIT_USB];
      mcd_en_d = sfr_wdata_i[reset_cause_pkg::BIT_MCD];
      vmon_d = sfr_wdata_i[reset_cause_pkg::BIT_POR];
    end
    case (state_q)
      reset_cause_pkg::ST_RUN: begin
        trig = 1'b1;
        usb_f_d = 1'b0;
        flash_f_d = 1'b0;
        soft_f_d = 1'b0;
        mcd_f_d = 1'b0;
        por_f_d = 1'b0;
        pin_f_d = 1'b0;
        // One cause latched per reset, fixed priority
        if (s[reset_cause_pkg::SRC_PIN]) begin
          pin_f_d = 1'b1;
        end else if (s[reset_cause_pkg::SRC_SUPPLY_LOW] && (vmon_q || vmon_d)) begin
          por_f_d = 1'b1;
        end else if (s[reset_cause_pkg::SRC_MCD] && mcd_en_q) begin
          mcd_f_d = 1'b1;
        end else if (s[reset_cause_pkg::SRC_FLASH]) begin
          flash_f_d = 1'b1;
        end else if (s[reset_cause_pkg::SRC_USB] && usb_en_q) begin
          usb_f_d = 1'b1;
        end else if (soft_req) begin
          soft_f_d = 1'b1;
        end else begin
          trig = 1'b0;
          usb_f_d = usb_f_q;
          flash_f_d = flash_f_q;
          soft_f_d = soft_f_q;
          mcd_f_d = mcd_f_q;
          por_f_d = por_f_q;
          pin_f_d = pin_f_q;
        end
        if (trig) begin
          // Causes are latched as the reset starts, before any read
          state_d = reset_cause_pkg::ST_HOLD;
          cnt_d = CNT_W'(HOLD_CYC);
          sys_reset_d = 1'b1;
          usb_en_d = 1'b0;
          mcd_en_d = 1'b0;
        end
      end
      reset_cause_pkg::ST_HOLD: begin
        usb_en_d = 1'b0;
        mcd_en_d = 1'b0;
        vmon_d = vmon_q;
        if (cnt_q > CNT_W'(1)) begin
          cnt_d = cnt_q - CNT_W'(1);
        end else if (s[reset_cause_pkg::SRC_PIN]) begin
          cnt_d = CNT_W'(1);
        end else begin
          cnt_d = '0;
          sys_reset_d = 1'b0;
          state_d = reset_cause_pkg::ST_RUN;
        end
      end
      default: begin
        state_d = reset_cause_pkg::ST_RUN;
      end
    endcase
    // Read data held until the next read strobe
    rdata_d = rdata_q;
    if (sfr_rd_i) begin
      rdata_d = reset_cause_pkg::READ_ZERO;
      if (hit(sfr_addr_i)) begin
        rdata_d[reset_cause_pkg::BIT_USB] = usb_f_q;
        rdata_d[reset_cause_pkg::BIT_FLASH] = flash_f_q;
        rdata_d[reset_cause_pkg::BIT_SOFT] = soft_f_q;
        // MCD and pin flags read zero after power-on; the power-on flag reads one
        rdata_d[reset_cause_pkg::BIT_MCD] = mcd_f_q;
        rdata_d[reset_cause_pkg::BIT_POR] = por_f_q;
        rdata_d[reset_cause_pkg::BIT_PIN] = pin_f_q;
      end
    end
  end

  // Power-on reset leaves only the power-on flag set
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      state_q <= reset_cause_pkg::ST_RUN;
      cnt_q <= '0;
      usb_f_q <= reset_cause_pkg::RESET_CAUSE_POR_VALUE[reset_cause_pkg::BIT_USB];
      flash_f_q <= reset_cause_pkg::RESET_CAUSE_POR_VALUE[reset_cause_pkg::BIT_FLASH];
      soft_f_q <= reset_cause_pkg::RESET_CAUSE_POR_VALUE[reset_cause_pkg::BIT_SOFT];
      mcd_f_q <= reset_cause_pkg::RESET_CAUSE_POR_VALUE[reset_cause_pkg::BIT_MCD];
      por_f_q <= reset_cause_pkg::RESET_CAUSE_POR_VALUE[reset_cause_pkg::BIT_POR];
      pin_f_q <= reset_cause_pkg::RESET_CAUSE_POR_VALUE[reset_cause_pkg::BIT_PIN];
      usb_en_q <= 1'b0;
      mcd_en_q <= 1'b0;
      vmon_q <= 1'b0;
      sys_reset_q <= 1'b0;
      rdata_q <= reset_cause_pkg::READ_ZERO;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      usb_f_q <= usb_f_d;
      flash_f_q <= flash_f_d;
      soft_f_q <= soft_f_d;
      mcd_f_q <= mcd_f_d;
      por_f_q <= por_f_d;
      pin_f_q <= pin_f_d;
      usb_en_q <= usb_en_d;
      mcd_en_q <= mcd_en_d;
      vmon_q <= vmon_d;
      sys_reset_q <= sys_reset_d;
      rdata_q <= rdata_d;
    end
  end

  assign sfr_rdata_o = rdata_q;
  assign sys_reset_o = sys_reset_q;
  assign usb_reset_en_o = usb_en_q;
  assign missing_clock_en_o = mcd_en_q;
  assign supply_monitor_sel_o = vmon_q;
endmodule

// File: bench/reset_cause_reg_assertions.sv
`timescale 1ns/100ps
module reset_cause_reg_assertions #(
  parameter int unsigned HOLD_CYC = 4
) (
  // Design ports
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [7:0] sfr_addr_i,
  input wire logic sfr_wr_i,
  input wire logic sfr_rd_i,
  input wire logic [7:0] sfr_wdata_i,
  input wire logic [7:0] sfr_rdata_o,
  input wire logic pin_reset_i,
  input wire logic flash_fault_i,
  input wire logic sys_reset_o,
  input wire logic usb_reset_en_o,
  input wire logic missing_clock_en_o,
  input wire logic supply_monitor_sel_o
);
  logic wr_ok;
  logic [7:0] hold_d;
  logic [7:0] hold_q;
  assign wr_ok = sfr_wr_i && sfr_addr_i == 8'hef && !sfr_wdata_i[4] && !sys_reset_o;
  // Cycles the reset request has stood
  always_comb hold_d = sys_reset_o ? hold_q + 8'h01 : 8'h00;
  always_ff @(posedge clk_i) begin
    hold_q <= rst_n_i ? hold_d : 8'h00;
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  unused_zero_a:
    assert property (sfr_rd_i |=> !sfr_rdata_o[5] && !sfr_rdata_o[3]) else $error("unused");
  soft_trigger_a:
    assert property (sfr_wr_i && sfr_addr_i == 8'hef && sfr_wdata_i[4] |=> sys_reset_o)
    else $error("soft");
  hold_len_a:
    assert property ($fell(sys_reset_o) |-> hold_q >= HOLD_CYC) else $error("hold");
  usb_enable_a:
    assert property (wr_ok |=> usb_reset_en_o == $past(sfr_wdata_i[7])) else $error("usb");
  mcd_enable_a:
    assert property (wr_ok |=> missing_clock_en_o == $past(sfr_wdata_i[2])) else $error("mcd");
  supply_select_a:
    assert property (wr_ok |=> supply_monitor_sel_o == $past(sfr_wdata_i[1]))
    else $error("sel");
  pin_trigger_a:
    assert property ($rose(pin_reset_i) |-> ##[1:4] sys_reset_o) else $error("pin");
  flash_trigger_a:
    assert property ($rose(flash_fault_i) |-> ##[1:4] sys_reset_o) else $error("flash");
endmodule

bind reset_cause_reg reset_cause_reg_assertions #(.HOLD_CYC(HOLD_CYC)) i_chk (.clk_i,
  .rst_n_i, .sfr_addr_i, .sfr_wr_i, .sfr_rd_i, .sfr_wdata_i, .sfr_rdata_o, .pin_reset_i,
  .flash_fault_i, .sys_reset_o, .usb_reset_en_o, .missing_clock_en_o, .supply_monitor_sel_o);

// File: bench/source_model.sv
`timescale 1ns/100ps
module source_model (
  // Clock and command
  input wire logic clk_i,
  input wire logic fire_i,
  input wire logic [2:0] pick_i,
  // Source levels
  output logic [4:0] src_o
);
  logic [1:0] left_q = 2'h0;
  logic [2:0] pick_q = 3'h0;
  // Held three cycles so the two-flop sync sees it
  always_ff @(posedge clk_i) begin
    left_q <= fire_i ? 2'h3 : left_q - 2'(left_q != 2'h0);
    pick_q <= fire_i ? pick_i : pick_q;
  end
  assign src_o = (left_q != 2'h0) ? 5'h01 << pick_q : 5'h00;
endmodule

// File: bench/tb_reset_cause_reg.sv
`timescale 1ns/100ps
module tb_reset_cause_reg;
  logic clk_i;
  logic rst_n_i;
  logic [7:0] sfr_addr_i;
  logic sfr_wr_i;
  logic sfr_rd_i;
  logic [7:0] sfr_wdata_i;
  logic [7:0] sfr_rdata_o;
  logic sys_reset_o;
  logic fire;
  logic [2:0] pick;
  logic [4:0] src;
  wire [2:0] en;
  int num_errors;
  int samples_checked;
  logic [7:0] exp_tab [5] = '{8'h01, 8'h02, 8'h04, 8'h40, 8'h80};
  source_model i_src (.clk_i, .fire_i(fire), .pick_i(pick), .src_o(src));
  reset_cause_reg i_dut (.clk_i, .rst_n_i, .sfr_addr_i, .sfr_wr_i, .sfr_rd_i, .sfr_wdata_i,
    .sfr_rdata_o, .pin_reset_i(src[0]), .supply_low_i(src[1]), .missing_clock_i(src[2]),
    .flash_fault_i(src[3]), .usb_reset_i(src[4]), .sys_reset_o, .usb_reset_en_o(en[2]),
    .missing_clock_en_o(en[1]), .supply_monitor_sel_o(en[0]));
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] d);
    @(posedge clk_i);
    sfr_wr_i <= 1'b1;
    sfr_addr_i <= 8'hef;
    sfr_wdata_i <= d;
    @(posedge clk_i);
    sfr_wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk_i);
    sfr_rd_i <= 1'b1;
    sfr_addr_i <= a;
    @(posedge clk_i);
    sfr_rd_i <= 1'b0;
    @(posedge clk_i);
    #1 check("read data", sfr_rdata_o, exp);
  endtask
  task automatic fire_src(input int k);
    @(posedge clk_i);
    fire <= 1'b1;
    pick <= 3'(k);
    @(posedge clk_i);
    fire <= 1'b0;
  endtask
  task automatic sys_cycle(input logic up);
    for (int n = 0; n < 30 && sys_reset_o !== up; n++) begin
      @(posedge clk_i);
      #1;
    end
    check("reset request", {7'h00, sys_reset_o}, {7'h00, up});
  endtask
  task automatic wrap_up();
    $display("checks %0d, mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end
  initial begin
    #20000;
    num_errors++;
    wrap_up();
  end
  initial begin
    {num_errors, samples_checked} = '0;
    {rst_n_i, sfr_wr_i, sfr_rd_i, fire, pick, sfr_addr_i, sfr_wdata_i} = '0;
    repeat (2) @(posedge clk_i);
    rst_n_i <= 1'b1;
    rd(8'hef, 8'h02);
    rd(8'h00, 8'h00);
    $display("test 1 done");
    wr(8'h10);
    sys_cycle(1'b1);
    sys_cycle(1'b0);
    rd(8'hef, 8'h10);
    wr(8'h84);
    rd(8'hef, 8'h10);
    check("enables", {5'h00, en}, 8'h06);
    wr(8'h6b);
    rd(8'hef, 8'h10);
    check("enables", {5'h00, en}, 8'h01);
    $display("test 2 done");
    for (int k = 0; k < 5; k++) begin
      wr(8'h86);
      fire_src(k);
      sys_cycle(1'b1);
      sys_cycle(1'b0);
      rd(8'hef, exp_tab[k]);
    end
    $display("test 3 done");
    wr(8'h00);
    for (int k = 1; k <= 4; k += (k == 2) ? 2 : 1) begin
      fire_src(k);
      repeat (5) @(posedge clk_i);
      #1 check("idle request", {7'h00, sys_reset_o}, 8'h00);
    end
    rd(8'hef, 8'h80);
    $display("test 4 done");
    wrap_up();
  end
endmodule
